// [pkg/pmp_consts.svh]
`ifndef PMP_CONSTS_SVH
`define PMP_CONSTS_SVH

// ============================================================
// Register indexes (byte address = 4 * index)
`define PMP_IDX_STATUS    16'h0000
`define PMP_IDX_CTRL      16'h0001
`define PMP_IDX_VIOL      16'h0002
`define PMP_IDX_USERID0   16'h8000
`define PMP_IDX_USERID3   16'h8003

// ============================================================
// Field positions
`define PMP_ST_CP_N       0
`define PMP_ST_DP_N       1
`define PMP_ST_APP_WP     2
`define PMP_ST_SAF_WP     3
`define PMP_ST_BOOT_WP    4
`define PMP_ST_CFG_WP     5
`define PMP_ST_CFG_VALID  8
`define PMP_CTRL_SW_EN    0
`define PMP_VIOL_EXT_RD   0
`define PMP_VIOL_EXT_WR   1
`define PMP_VIOL_SELF_WR  2

// ============================================================
// Reset values
`define PMP_CTRL_RST      1'b0
`define PMP_USERID_RST    14'h0000

// ============================================================
// Program memory region bounds, word addresses, upper bound exclusive
`define PMP_BOOT_LO       16'h0000
`define PMP_BOOT_HI       16'h0800
`define PMP_APP_LO        16'h0800
`define PMP_APP_HI        16'h3800
`define PMP_SAF_LO        16'h3800
`define PMP_SAF_HI        16'h4000
`define PMP_CFGA_LO       16'h8007
`define PMP_CFGA_HI       16'h800C

// ============================================================
// Read pipeline depth from request to answer
`define PMP_RD_LAT        2

`endif

// [pkg/pmp_pkg.sv]
package pmp_pkg;

  // ============================================================
  // Shared widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_W = 14;

  // Latched protection configuration; write protects are active high
  typedef struct packed {
    logic code_protect_n;
    logic data_protect_n;
    logic app_region_write_protect;
    logic storage_area_write_protect;
    logic boot_region_write_protect;
    logic config_region_write_protect;
  } pmp_cfg_t;

  // One access towards the program memory array
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } pmp_mem_req_t;

  // Who owns a read in flight
  typedef enum logic [1:0] {
    PMP_SRC_NONE,
    PMP_SRC_CPU,
    PMP_SRC_EXT
  } pmp_src_t;

endpackage

// [design/pmp_region_gate.sv]
`timescale 1ns/1ps
`include "pmp_consts.svh"

module pmp_region_gate #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'h0001
) (
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        protect_i,
  output logic             hit_o,
  output logic             block_o
);

  // ============================================================
  // Elaboration check
  if (HI <= LO) begin : g_bad_bounds
    $error("pmp_region_gate: empty region");
  end

  // ============================================================
  // Region decode; only this region's own bit blocks it
  assign hit_o   = (addr_i >= LO) && (addr_i < HI);
  assign block_o = hit_o && wr_i && protect_i;

endmodule

// [design/pmp_top.sv]
`timescale 1ns/1ps
`include "pmp_consts.svh"

module pmp_top (
  input  wire logic                    clk_sys_i,
  input  wire logic                    arst_n_i,
  // Configuration words seen at reset
  input  wire pmp_pkg::pmp_cfg_t       cfg_word_i,
  // Avalon-MM slave
  input  wire logic [17:0]             avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  output logic [31:0]                  avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // CPU read port
  input  wire logic                    cpu_rd_i,
  input  wire logic [15:0]             cpu_addr_i,
  output logic [13:0]                  cpu_rdata_o,
  output logic                         cpu_rvalid_o,
  // CPU self-write port
  input  wire logic                    self_wr_i,
  input  wire logic [15:0]             self_addr_i,
  input  wire logic [13:0]             self_wdata_i,
  output logic                         self_ready_o,
  output logic                         self_blocked_o,
  // External programmer port
  input  wire logic                    ext_req_i,
  input  wire logic                    ext_wr_i,
  input  wire logic [15:0]             ext_addr_i,
  input  wire logic [13:0]             ext_wdata_i,
  output logic                         ext_ready_o,
  output logic [13:0]                  ext_rdata_o,
  output logic                         ext_rvalid_o,
  // Program memory array port
  output pmp_pkg::pmp_mem_req_t        mem_req_o,
  input  wire logic [13:0]             mem_rdata_i,
  // Data memory external gate
  output logic                         data_ext_allow_o
);
  import pmp_pkg::*;

  // ============================================================
  // Configuration capture
  pmp_cfg_t cfg_r;
  logic     cfg_valid_r;

  // Caught on first edge after release, then frozen until next reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_r       <= '0;
      cfg_valid_r <= 1'b0;
    end else if (!cfg_valid_r) begin
      cfg_r       <= cfg_word_i;
      cfg_valid_r <= 1'b1;
    end
  end

  // ============================================================
  // Software registers
  logic        sw_en_r;
  logic [2:0]  viol_r;
  logic [2:0]  viol_nxt;
  logic [13:0] userid_r [4];

  // ============================================================
  // Region decode for self-writes
  logic app_hit, saf_hit, boot_hit, cfga_hit;
  logic app_blk, saf_blk, boot_blk, cfga_blk;

  pmp_region_gate #(.LO(`PMP_APP_LO), .HI(`PMP_APP_HI)) u_gate_app (
    .addr_i    (self_addr_i),
    .wr_i      (self_wr_i),
    .protect_i (cfg_r.app_region_write_protect),
    .hit_o     (app_hit),
    .block_o   (app_blk)
  );

  pmp_region_gate #(.LO(`PMP_SAF_LO), .HI(`PMP_SAF_HI)) u_gate_saf (
    .addr_i    (self_addr_i),
    .wr_i      (self_wr_i),
    .protect_i (cfg_r.storage_area_write_protect),
    .hit_o     (saf_hit),
    .block_o   (saf_blk)
  );

  pmp_region_gate #(.LO(`PMP_BOOT_LO), .HI(`PMP_BOOT_HI)) u_gate_boot (
    .addr_i    (self_addr_i),
    .wr_i      (self_wr_i),
    .protect_i (cfg_r.boot_region_write_protect),
    .hit_o     (boot_hit),
    .block_o   (boot_blk)
  );

  pmp_region_gate #(.LO(`PMP_CFGA_LO), .HI(`PMP_CFGA_HI)) u_gate_cfga (
    .addr_i    (self_addr_i),
    .wr_i      (self_wr_i),
    .protect_i (cfg_r.config_region_write_protect),
    .hit_o     (cfga_hit),
    .block_o   (cfga_blk)
  );

  // ============================================================
  // Elaboration checks; the decode below leans on this map
  if (`PMP_BOOT_HI > `PMP_APP_LO || `PMP_APP_HI > `PMP_SAF_LO) begin : g_bad_map
    $error("pmp_top: program memory regions overlap");
  end
  if ((`PMP_IDX_USERID3 - `PMP_IDX_USERID0 != 16'h0003) ||
      ((`PMP_IDX_USERID0 & 16'h0003) != 16'h0000)) begin : g_bad_uid
    $error("pmp_top: user ID window must be four aligned words");
  end
  // The answer stage below is exactly two edges deep
  if (`PMP_RD_LAT != 2) begin : g_bad_lat
    $error("pmp_top: read latency is fixed at two edges");
  end

  // ============================================================
  // Access decisions
  wire self_any_hit = app_hit | saf_hit | boot_hit | cfga_hit;
  // Code protect deliberately absent here; unmapped addresses refused
  wire self_deny    = app_blk | saf_blk | boot_blk | cfga_blk
                    | ~self_any_hit | ~sw_en_r | ~cfg_valid_r;
  // Refuse everything until the configuration is known (fail safe)
  wire ext_deny     = ~cfg_r.code_protect_n | ~cfg_valid_r;
  wire ext_rd       = ext_req_i & ~ext_wr_i;
  wire ext_wrq      = ext_req_i & ext_wr_i;

  // ============================================================
  // Single array port: CPU read first, self-write next, programmer last
  // A request held high is taken again at every edge it stands
  wire grant_cpu  = cpu_rd_i;
  wire grant_self = self_wr_i & ~cpu_rd_i;
  wire grant_ext  = ext_req_i & ~cpu_rd_i & ~self_wr_i;

  assign self_ready_o   = grant_self;
  assign self_blocked_o = grant_self & self_deny;
  assign ext_ready_o    = grant_ext;

  // Refused external requests never reach the array
  wire do_cpu_rd  = grant_cpu;
  wire do_self_wr = grant_self & ~self_deny;
  wire do_ext_rd  = grant_ext & ext_rd & ~ext_deny;
  wire do_ext_wr  = grant_ext & ext_wrq & ~ext_deny;

  pmp_mem_req_t mem_req_nxt;
  always_comb begin
    mem_req_nxt       = '0;
    mem_req_nxt.rd    = do_cpu_rd | do_ext_rd;
    mem_req_nxt.wr    = do_self_wr | do_ext_wr;
    mem_req_nxt.addr  = do_cpu_rd  ? cpu_addr_i  :
                        grant_self ? self_addr_i : ext_addr_i;
    mem_req_nxt.wdata = grant_self ? self_wdata_i : ext_wdata_i;
  end

  // Registered array request; the array answers while it stands,
  // so read data is taken at the very next edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_req_o <= '0;
    end else begin
      mem_req_o <= mem_req_nxt;
    end
  end

  // ============================================================
  // Read tracking: every granted read answers, refused ones with zeros
  pmp_src_t src_r;
  logic     zero_r;
  wire      src_ext = grant_ext & ext_rd;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_r  <= PMP_SRC_NONE;
      zero_r <= 1'b0;
    end else begin
      src_r  <= grant_cpu ? PMP_SRC_CPU : (src_ext ? PMP_SRC_EXT : PMP_SRC_NONE);
      zero_r <= src_ext & ext_deny;
    end
  end

  // Answer stage: two edges from request to valid
  // Read data holds between answers; only the valid flags pulse
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cpu_rdata_o  <= '0;
      cpu_rvalid_o <= 1'b0;
      ext_rdata_o  <= '0;
      ext_rvalid_o <= 1'b0;
    end else begin
      cpu_rvalid_o <= (src_r == PMP_SRC_CPU);
      ext_rvalid_o <= (src_r == PMP_SRC_EXT);
      if (src_r == PMP_SRC_CPU) begin
        cpu_rdata_o <= mem_rdata_i;
      end
      if (src_r == PMP_SRC_EXT) begin
        ext_rdata_o <= zero_r ? 14'h0000 : mem_rdata_i;
      end
    end
  end

  // ============================================================
  // Data memory gate, driven by its own latched bit and the config valid flag only
  assign data_ext_allow_o = cfg_r.data_protect_n & cfg_valid_r;

  // ============================================================
  // Violation flags; a new event beats a clear in the same cycle
  wire [2:0] viol_evt = {self_blocked_o,
                         grant_ext & ext_wrq & ext_deny,
                         grant_ext & ext_rd & ext_deny};

  // ============================================================
  // Avalon-MM slave: one wait cycle, then the answer
  logic        ack_r;
  logic [31:0] rdata_nxt;
  wire         bus_req   = avs_read_i | avs_write_i;
  wire [15:0]  reg_idx   = avs_address_i[17:2];
  wire         aligned   = (avs_address_i[1:0] == 2'b00);
  wire         hit_stat  = aligned && (reg_idx == `PMP_IDX_STATUS);
  wire         hit_ctrl  = aligned && (reg_idx == `PMP_IDX_CTRL);
  wire         hit_viol  = aligned && (reg_idx == `PMP_IDX_VIOL);
  wire         hit_uid   = aligned && (reg_idx >= `PMP_IDX_USERID0)
                                   && (reg_idx <= `PMP_IDX_USERID3);
  wire [1:0]   uid_sel   = reg_idx[1:0];
  wire         wr_commit = avs_write_i & ack_r;

  // Every access, mapped or not, pays exactly one wait state
  assign avs_waitrequest_o = bus_req & ~ack_r;

  // Read mux; unmapped and misaligned addresses read zero
  always_comb begin
    rdata_nxt = '0;
    if (hit_stat) begin
      rdata_nxt[`PMP_ST_CP_N]      = cfg_r.code_protect_n;
      rdata_nxt[`PMP_ST_DP_N]      = cfg_r.data_protect_n;
      rdata_nxt[`PMP_ST_APP_WP]    = cfg_r.app_region_write_protect;
      rdata_nxt[`PMP_ST_SAF_WP]    = cfg_r.storage_area_write_protect;
      rdata_nxt[`PMP_ST_BOOT_WP]   = cfg_r.boot_region_write_protect;
      rdata_nxt[`PMP_ST_CFG_WP]    = cfg_r.config_region_write_protect;
      rdata_nxt[`PMP_ST_CFG_VALID] = cfg_valid_r;
    end else if (hit_ctrl) begin
      rdata_nxt[`PMP_CTRL_SW_EN]   = sw_en_r;
    end else if (hit_viol) begin
      rdata_nxt[2:0]               = viol_r;
    end else if (hit_uid) begin
      rdata_nxt[13:0]              = userid_r[uid_sel];
    end
  end

  // Write-one-to-clear, with set priority over clear
  always_comb begin
    viol_nxt = viol_r;
    if (wr_commit && hit_viol) begin
      viol_nxt = viol_nxt & ~avs_writedata_i[2:0];
    end
    viol_nxt = viol_nxt | viol_evt;
  end

  // Handshake and read data capture
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r          <= 1'b0;
      avs_readdata_o <= '0;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (avs_read_i && !ack_r) begin
        avs_readdata_o <= rdata_nxt;
      end
    end
  end

  // Control and flags
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_en_r <= `PMP_CTRL_RST;
      viol_r  <= '0;
    end else begin
      viol_r <= viol_nxt;
      if (wr_commit && hit_ctrl) begin
        sw_en_r <= avs_writedata_i[`PMP_CTRL_SW_EN];
      end
    end
  end

  // User ID words, writable during normal running
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        userid_r[i] <= `PMP_USERID_RST;
      end
    end else if (wr_commit && hit_uid) begin
      userid_r[uid_sel] <= avs_writedata_i[13:0];
    end
  end

endmodule

// [verif/pmp_prog_model.sv]
`timescale 1ns/1ps
module pmp_prog_model (
  input  wire logic        clk_i,
  output logic             ext_req_o,
  output logic             ext_wr_o,
  output logic [15:0]      ext_addr_o,
  output logic [13:0]      ext_wdata_o,
  input  wire logic        ext_ready_i,
  input  wire logic [13:0] ext_rdata_i,
  input  wire logic        ext_rvalid_i
);
  // ============================================================
  // Programmer starts with its lines at zero; after each request the request drops and the other lines are inverted, never last value
  initial begin
    ext_req_o = 1'b0;
    ext_wr_o = 1'b0;
    ext_addr_o = 16'h0000;
    ext_wdata_o = 14'h0000;
  end
  // One word per request; dly makes a slow programmer
  task automatic op(input bit w, input logic [15:0] a, input logic [13:0] d,
                    input int dly, output logic [13:0] rd, output bit ok);
    int n;
    rd = 14'h0000;
    repeat (dly + 1) @(posedge clk_i);
    ext_req_o <= 1'b1;
    ext_wr_o <= w;
    ext_addr_o <= a;
    ext_wdata_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ext_ready_i !== 1'b1 && n < 20);
    ok = (ext_ready_i === 1'b1);
    ext_req_o <= 1'b0;
    ext_wr_o <= ~w;
    ext_addr_o <= ~a;
    ext_wdata_o <= ~d;
    if (!w) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (ext_rvalid_i !== 1'b1 && n < 8);
      ok = ok && ext_rvalid_i === 1'b1;
      rd = ext_rdata_i;
    end
  endtask
endmodule

// [verif/pmp_top_asserts.sv]
`timescale 1ns/1ps
module pmp_top_asserts (
  input wire logic                  clk_sys_i,
  input wire logic                  arst_n_i,
  input wire pmp_pkg::pmp_cfg_t     cfg_word_i,
  input wire logic                  cpu_rd_i,
  input wire logic [15:0]           cpu_addr_i,
  input wire logic                  cpu_rvalid_o,
  input wire logic [15:0]           self_addr_i,
  input wire logic [13:0]           self_wdata_i,
  input wire logic                  self_ready_o,
  input wire logic                  self_blocked_o,
  input wire logic                  ext_wr_i,
  input wire logic                  ext_ready_o,
  input wire logic [13:0]           ext_rdata_o,
  input wire logic                  ext_rvalid_o,
  input wire pmp_pkg::pmp_mem_req_t mem_req_o,
  input wire logic                  data_ext_allow_o
);
  import pmp_pkg::*;
  logic     valid_r;
  pmp_cfg_t cfg_r;
  logic     wp_hit;

  // ============================================================
  // Own copy of the settings, frozen after the first edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_r <= 1'b0;
      cfg_r <= '0;
    end else begin
      valid_r <= 1'b1;
      cfg_r <= valid_r ? cfg_r : cfg_word_i;
    end
  end
  // Self-write aimed at a locked region
  assign wp_hit = cfg_r.boot_region_write_protect && self_addr_i inside {[16'h0000:16'h07FF]}
    || cfg_r.app_region_write_protect && self_addr_i inside {[16'h0800:16'h37FF]}
    || cfg_r.storage_area_write_protect && self_addr_i inside {[16'h3800:16'h3FFF]}
    || cfg_r.config_region_write_protect && self_addr_i inside {[16'h8007:16'h800B]};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // ============================================================
  // Port relations
  cpu_fetch_a: assert property (
    cpu_rd_i |=> mem_req_o.rd && mem_req_o.addr == $past(cpu_addr_i)) else $error("cpu fetch");
  cpu_answer_a: assert property (cpu_rd_i |-> ##2 cpu_rvalid_o)
    else $error("cpu answer");
  ext_refuse_a: assert property (
    ext_ready_o && valid_r && !cfg_r.code_protect_n |=> !mem_req_o.rd && !mem_req_o.wr)
    else $error("ext not refused");
  ext_zero_a: assert property (
    ext_ready_o && !ext_wr_i && !(valid_r && cfg_r.code_protect_n)
    |-> ##2 ext_rvalid_o && ext_rdata_o == 14'h0000) else $error("ext read not zero");
  ext_pass_a: assert property (
    ext_ready_o && valid_r && cfg_r.code_protect_n
    |=> mem_req_o.wr == $past(ext_wr_i) && mem_req_o.rd != $past(ext_wr_i)) else $error("ext lost");
  self_lock_a: assert property (self_ready_o && wp_hit |-> self_blocked_o)
    else $error("self-write not blocked");
  self_go_a: assert property (
    self_ready_o && !self_blocked_o |=> mem_req_o.wr && mem_req_o.wdata == $past(self_wdata_i))
    else $error("self-write lost");
  data_sep_a: assert property (valid_r |=> data_ext_allow_o == cfg_r.data_protect_n)
    else $error("data gate");
endmodule

bind pmp_top pmp_top_asserts u_chk (.*);

// [verif/tb_pmp_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((e) !== (s)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module tb_pmp_top;
  import pmp_pkg::*;
  logic          clk_sys_i = 1'b0;
  logic          arst_n_i = 1'b0;
  pmp_cfg_t      cfg_word_i = '0;
  logic [17:0]   avs_address_i = '0;
  logic          avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0]   avs_writedata_i = '0, avs_readdata_o;
  logic          avs_waitrequest_o, cpu_rvalid_o, self_ready_o, self_blocked_o;
  logic          cpu_rd_i = 1'b0, self_wr_i = 1'b0, ext_req_i, ext_wr_i;
  logic [15:0]   cpu_addr_i = '0, self_addr_i = '0, ext_addr_i;
  logic [13:0]   self_wdata_i = '0, mem_rdata_i, ext_wdata_i, cpu_rdata_o, ext_rdata_o;
  logic          ext_ready_o, ext_rvalid_o, data_ext_allow_o;
  pmp_mem_req_t  mem_req_o;
  int            mismatches = 0, comparisons = 0, seed = 32'hEC06;
  logic [5:0]    cfgs [2] = '{6'b101010, 6'b010101};
  logic [15:0]   aa [6] = '{16'h07FF, 16'h0800, 16'h3FFF, 16'h8007, 16'h4000, 16'h800C};

  pmp_top uut (.*);
  pmp_prog_model prog (.clk_i(clk_sys_i), .ext_req_o(ext_req_i), .ext_wr_o(ext_wr_i),
    .ext_addr_o(ext_addr_i), .ext_wdata_o(ext_wdata_i), .ext_ready_i(ext_ready_o),
    .ext_rdata_i(ext_rdata_o), .ext_rvalid_i(ext_rvalid_o));

  // ============================================================
  // Clock and array stand-in; data is good only while a read stands
  always #2 clk_sys_i = ~clk_sys_i;
  assign mem_rdata_i = mem_req_o.rd ? pat(mem_req_o.addr) : ~pat(mem_req_o.addr);

  // ============================================================
  // Reference model
  function automatic logic [13:0] pat(input logic [15:0] a);
    return a[13:0] ^ 14'h2A5A;
  endfunction
  function automatic logic [31:0] stat(input logic [5:0] c);
    stat = 32'h0000_0100;
    for (int i = 0; i < 6; i++) stat[i] = c[5-i];
  endfunction
  // Region order: boot, app, storage, config; gaps always refuse
  function automatic bit blk(input logic [15:0] a, input logic [5:0] c);
    if (a < 16'h0800) return c[1];
    if (a < 16'h3800) return c[3];
    if (a < 16'h4000) return c[2];
    if (a >= 16'h8007 && a < 16'h800C) return c[0];
    return 1'b1;
  endfunction

  // ============================================================
  // Bus tasks
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic av(input bit w, input logic [15:0] ix, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_sys_i);
    avs_address_i <= {ix, 2'h0};
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= wd;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic self_write(input logic [15:0] a, input bit b);
    int n;
    @(posedge clk_sys_i);
    self_wr_i <= 1'b1;
    self_addr_i <= a;
    self_wdata_i <= 14'($random(seed));
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (self_ready_o !== 1'b1 && n < 8);
    `CHK("self_ready", 1'b1, self_ready_o)
    `CHK("self_block", b, self_blocked_o)
    self_wr_i <= 1'b0;
  endtask

  // ============================================================
  // Two settings, each behind its own reset
  initial begin
    logic [31:0] rd;
    logic [13:0] xd;
    logic [15:0] a;
    logic [5:0]  c;
    bit          ok;
    logic [31:0] wd;
    int          n;
    for (int p = 0; p < 2; p++) begin
      c = cfgs[p];
      arst_n_i <= 1'b0;
      cfg_word_i <= c;
      repeat (2) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      cfg_word_i <= ~c;
      av(1, 16'h0000, 32'hFFFF_FFFF, rd);
      av(0, 16'h0000, 0, rd);
      `CHK("status", stat(c), rd)
      av(0, 16'h0003, 0, rd);
      `CHK("unmapped", 32'h0, rd)
      `CHK("data_gate", c[4], data_ext_allow_o)
      self_write(16'h0100, 1'b1);
      av(1, 16'h0001, 32'h1, rd);
      foreach (aa[i]) self_write(aa[i], blk(aa[i], c));
      for (int i = 0; i < 3; i++) begin
        a = 16'($random(seed));
        @(posedge clk_sys_i);
        cpu_rd_i <= 1'b1;
        cpu_addr_i <= a;
        @(posedge clk_sys_i);
        cpu_rd_i <= 1'b0;
        cpu_addr_i <= ~a;
        n = 0;
        do begin
          @(posedge clk_sys_i);
          n++;
        end while (cpu_rvalid_o !== 1'b1 && n < 8);
        `CHK("cpu_lat", 2, n)
        `CHK("cpu_data", pat(a), cpu_rdata_o)
        prog.op(i[0], a, 14'($random(seed)), 2 * i, xd, ok);
        `CHK("ext_done", 1'b1, ok)
        if (!ok) finish_test();
        if (!i[0]) `CHK("ext_rdata", c[5] ? pat(a) : 14'h0, xd)
      end
      av(0, 16'h0002, 0, rd);
      `CHK("viol", c[5] ? 32'h4 : 32'h7, rd)
      av(1, 16'h0002, 32'h7, rd);
      av(0, 16'h0002, 0, rd);
      `CHK("viol_clear", 32'h0, rd)
      for (int i = 0; i < 4; i++) begin
        a = 16'h8000 + 16'(i);
        wd = $random(seed);
        av(0, a, 0, rd);
        `CHK("uid_reset", 32'h0, rd)
        av(1, a, wd, rd);
        av(0, a, 0, rd);
        `CHK("uid_hold", {18'h0, wd[13:0]}, rd)
      end
    end
    finish_test();
  end
endmodule
